// >>> ecs_pkg.sv
// package: constants, types and decoders shared by the expansion select timing block
package ecs_pkg;

    // ------------------------------------------------------------------
    // register map (word offsets on the plain register port)
    // ------------------------------------------------------------------
    localparam logic [7:0] ECS_OFF_CFG_LO  = 8'h00;  // selects 0..3 config bytes
    localparam logic [7:0] ECS_OFF_CFG_HI  = 8'h04;  // selects 4..5 plus fixed bytes
    localparam logic [7:0] ECS_OFF_CTRL    = 8'h08;  // card enables, bus rate
    localparam logic [7:0] ECS_OFF_STAT    = 8'h0C;  // strap, busy, ready level

    // ------------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------------
    localparam int ECS_CTRL_CARD4_BIT = 0;              // card interface on select 4
    localparam int ECS_CTRL_CARD5_BIT = 1;              // card interface on select 5
    localparam int ECS_CTRL_RATE_BIT  = 2;              // 1 = fast bus, 4-bit wait field
    localparam logic [31:0] ECS_CFG_RST  = 32'h0000_0000; // all config bytes cleared
    localparam logic [2:0]  ECS_CTRL_RST = 3'h0;
    localparam logic [7:0]  ECS_FIXED_SRAM_BYTE = 8'h00; // read-back of select 6 byte
    localparam logic [7:0]  ECS_FIXED_ROM_BYTE  = 8'h00; // read-back of select 7 byte

    // ------------------------------------------------------------------
    // timing counts
    // ------------------------------------------------------------------
    localparam logic [3:0] ECS_FAST_RND_BASE = 4'h8;  // random waits, fast bus
    localparam logic [3:0] ECS_FAST_SEQ_BASE = 4'h3;  // sequential waits, fast bus
    localparam logic [3:0] ECS_SLOW_RND_BASE = 4'h4;  // random waits, slow bus
    localparam logic [3:0] ECS_SLOW_SEQ_BASE = 4'h3;  // sequential waits, slow bus
    localparam logic [1:0] ECS_PAGE_LAST     = 2'h3;  // fourth word of a page run
    localparam logic [1:0] ECS_ACT_LIMIT     = 2'h3;  // active cycles before an idle
    localparam logic [2:0] ECS_SEL_SRAM      = 3'h6;  // internal sram select
    localparam logic [2:0] ECS_SEL_ROM       = 3'h7;  // boot rom select
    localparam logic [2:0] ECS_SEL_CARD4     = 3'h4;
    localparam logic [2:0] ECS_SEL_CARD5     = 3'h5;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ECS_W32, ECS_W16, ECS_W8, ECS_WRES
    } ecs_width_e;

    typedef struct packed {
        logic       exp_clock_enable;   // bit 7
        logic       seq_access_enable;  // bit 6
        logic [3:0] wait_field;         // bits 5:2
        logic [1:0] width_code;         // bits 1:0
    } ecs_cfg_s;

    typedef struct packed {
        logic [3:0] rnd_waits;
        logic [3:0] seq_waits;
    } ecs_waits_s;

    // wait decode, picked by bus rate
    function automatic ecs_waits_s ecs_decode_waits(input logic fast, input logic [3:0] f);
        ecs_waits_s w;
        w = '0;
        if (fast) begin
            w.rnd_waits = ECS_FAST_RND_BASE - {1'b0, f[2], 2'b00} - {2'b00, f[1:0]};
            w.seq_waits = ECS_FAST_SEQ_BASE - {2'b00, f[3:2]};
        end else begin
            w.rnd_waits = ECS_SLOW_RND_BASE - {2'b00, f[1:0]};
            w.seq_waits = ECS_SLOW_SEQ_BASE - {2'b00, f[1:0]};
        end
        return w;
    endfunction

    // width decode; the strap, its two bits swapped, is folded in by exclusive-or
    function automatic ecs_width_e ecs_decode_width(input logic [1:0] code,
                                                    input logic [1:0] strap);
        return ecs_width_e'(code ^ {strap[0], strap[1]});
    endfunction

endpackage

// >>> ecs_top.sv
// expansion bus select timing: config registers and access sequencer
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - internal sram select: 32-bit, zero waits
// - boot rom select: 8-bit, zero waits
// - enabled card selects use multiplexed 16-bit bus
// - enabled card select ignores its config byte
// - fast bus: four-bit wait field decode
// - sequential enable gives page timing from quad boundary
// - page run breaks after four words
// - without sequential enable, idle every four cycles
// - clock enable drives expansion clock during accesses
// - back-to-back accesses keep expansion clock running
// - slow bus: two-bit wait field decode
// - config byte layout clock, seq, wait, width
// - width code mapping xored with the boot strap, its two bits swapped
module ecs_top
    import ecs_pkg::*;
#(
    parameter int SEL_COUNT  = 8,      // select lines driven
    parameter int CARD_WAITS = 2       // fixed waits on an enabled card select
) (
    // clocks and resets
    input  wire logic         i_clk,
    input  wire logic         i_rst_n,
    input  wire logic         i_lnk_clk,
    input  wire logic         i_lnk_rst_n,
    // register port
    input  wire logic [7:0]   i_addr,
    input  wire logic [31:0]  i_wdata,
    input  wire logic         i_wr,
    input  wire logic         i_rd,
    output logic      [31:0]  o_rdata,
    // access request port
    input  wire logic         i_req_valid,
    input  wire logic [2:0]   i_req_sel,
    input  wire logic         i_req_seq,
    input  wire logic [27:0]  i_req_addr,
    output logic              o_busy,
    output logic              o_done,
    // expansion pins
    input  wire logic [1:0]   i_boot_width_strap,
    input  wire logic         i_expansion_ready_in,
    output logic [SEL_COUNT-1:0] o_chip_select_n,
    output logic              o_expansion_clock_out,
    output ecs_width_e        o_bus_width,
    output logic              o_mux_mode,
    output logic [3:0]        o_wait_count
);

    // ------------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------------
    if (SEL_COUNT != 8) begin : g_bad_sel
        $error("ecs_top: SEL_COUNT must be 8");
    end
    if (CARD_WAITS < 0 || CARD_WAITS > 15) begin : g_bad_card
        $error("ecs_top: CARD_WAITS must fit four bits");
    end
    localparam logic [3:0] CARD_W = 4'(CARD_WAITS);

    // ------------------------------------------------------------------
    // link domain: ready pin synchronised on the link clock
    // ------------------------------------------------------------------
    logic lnk_rdy_meta_r, lnk_rdy_meta_nxt;  // first stage, read by second only
    logic lnk_rdy_r,      lnk_rdy_nxt;       // stable ready level, link domain

    // next state of the link-side synchroniser
    always_comb begin
        lnk_rdy_meta_nxt = i_expansion_ready_in;
        lnk_rdy_nxt      = lnk_rdy_meta_r;
    end

    // registers of the link domain
    always_ff @(posedge i_lnk_clk) begin
        if (!i_lnk_rst_n) begin
            lnk_rdy_meta_r <= 1'b1;
            lnk_rdy_r      <= 1'b1;
        end else begin
            lnk_rdy_meta_r <= lnk_rdy_meta_nxt;
            lnk_rdy_r      <= lnk_rdy_nxt;
        end
    end

    // ------------------------------------------------------------------
    // crossings into the bus clock: ready level and boot strap
    // ------------------------------------------------------------------
    logic       rdy_meta_r,   rdy_meta_nxt;    // first stage of ready crossing
    logic       rdy_r,        rdy_nxt;         // ready, bus domain
    logic [1:0] strap_meta_r, strap_meta_nxt;  // first stage of strap sync
    logic [1:0] strap_sync_r, strap_sync_nxt;
    logic [1:0] strap_r,      strap_nxt;       // strap caught after reset
    logic       strap_done_r, strap_done_nxt;

    // a level crosses with two flops; the strap is caught once after release
    always_comb begin
        rdy_meta_nxt   = lnk_rdy_r;
        rdy_nxt        = rdy_meta_r;
        strap_meta_nxt = i_boot_width_strap;
        strap_sync_nxt = strap_meta_r;
        strap_nxt      = strap_r;
        strap_done_nxt = strap_done_r;
        if (!strap_done_r) begin
            strap_nxt      = strap_sync_r;
            strap_done_nxt = 1'b1;
        end
    end

    // registers of the crossings
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            rdy_meta_r   <= 1'b1;
            rdy_r        <= 1'b1;
            strap_meta_r <= strap_meta_nxt;  // keeps sampling so the catch sees the pin
            strap_sync_r <= strap_sync_nxt;
            strap_r      <= 2'h0;
            strap_done_r <= 1'b0;
        end else begin
            rdy_meta_r   <= rdy_meta_nxt;
            rdy_r        <= rdy_nxt;
            strap_meta_r <= strap_meta_nxt;
            strap_sync_r <= strap_sync_nxt;
            strap_r      <= strap_nxt;
            strap_done_r <= strap_done_nxt;
        end
    end

    // ------------------------------------------------------------------
    // register file
    // ------------------------------------------------------------------
    logic [31:0] cfg_lo_r, cfg_lo_nxt;  // selects 0..3
    logic [15:0] cfg_hi_r, cfg_hi_nxt;  // selects 4..5; upper bytes fixed
    logic [2:0]  ctrl_r,   ctrl_nxt;    // card enables and bus rate
    logic [31:0] rdata_r,  rdata_nxt;
    logic        busy_r;                // driven by the sequencer below

    // writes store, reads return in the following cycle only
    always_comb begin
        cfg_lo_nxt = cfg_lo_r;
        cfg_hi_nxt = cfg_hi_r;
        ctrl_nxt   = ctrl_r;
        rdata_nxt  = 32'h0000_0000;
        if (i_wr) begin
            case (i_addr)
                ECS_OFF_CFG_LO: cfg_lo_nxt = i_wdata;
                ECS_OFF_CFG_HI: cfg_hi_nxt = i_wdata[15:0];  // fixed bytes drop writes
                ECS_OFF_CTRL:   ctrl_nxt   = i_wdata[2:0];
                default: ;                                   // unmapped: ignored
            endcase
        end
        if (i_rd) begin
            case (i_addr)
                ECS_OFF_CFG_LO: rdata_nxt = cfg_lo_r;
                ECS_OFF_CFG_HI: rdata_nxt = {ECS_FIXED_ROM_BYTE, ECS_FIXED_SRAM_BYTE, cfg_hi_r};
                ECS_OFF_CTRL:   rdata_nxt = {29'h0000_0000, ctrl_r};
                ECS_OFF_STAT:   rdata_nxt = {28'h000_0000, rdy_r, busy_r, strap_r};
                default:        rdata_nxt = 32'h0000_0000;   // unmapped reads zero
            endcase
        end
    end

    // registers of the register file
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            cfg_lo_r <= ECS_CFG_RST;
            cfg_hi_r <= ECS_CFG_RST[15:0];
            ctrl_r   <= ECS_CTRL_RST;
            rdata_r  <= 32'h0000_0000;
        end else begin
            cfg_lo_r <= cfg_lo_nxt;
            cfg_hi_r <= cfg_hi_nxt;
            ctrl_r   <= ctrl_nxt;
            rdata_r  <= rdata_nxt;
        end
    end
    assign o_rdata = rdata_r;

    // ------------------------------------------------------------------
    // per-request decode of the selected configuration
    // ------------------------------------------------------------------
    ecs_cfg_s   req_cfg;    // byte of the requested select
    ecs_waits_s req_waits;  // decoded waits
    ecs_width_e req_width;
    logic       req_mux;
    logic       req_card;   // card interface owns this select

    // fixed selects and enabled card selects override the byte
    always_comb begin
        case (i_req_sel)
            3'h0: req_cfg = ecs_cfg_s'(cfg_lo_r[7:0]);
            3'h1: req_cfg = ecs_cfg_s'(cfg_lo_r[15:8]);
            3'h2: req_cfg = ecs_cfg_s'(cfg_lo_r[23:16]);
            3'h3: req_cfg = ecs_cfg_s'(cfg_lo_r[31:24]);
            3'h4: req_cfg = ecs_cfg_s'(cfg_hi_r[7:0]);
            3'h5: req_cfg = ecs_cfg_s'(cfg_hi_r[15:8]);
            default: req_cfg = ecs_cfg_s'(8'h00);
        endcase
        req_card = (i_req_sel == ECS_SEL_CARD4 && ctrl_r[ECS_CTRL_CARD4_BIT])
                || (i_req_sel == ECS_SEL_CARD5 && ctrl_r[ECS_CTRL_CARD5_BIT]);
        req_waits = ecs_decode_waits(ctrl_r[ECS_CTRL_RATE_BIT], req_cfg.wait_field);
        req_width = ecs_decode_width(req_cfg.width_code, strap_r);
        req_mux   = 1'b0;
        if (i_req_sel == ECS_SEL_SRAM) begin
            req_cfg   = ecs_cfg_s'(8'h00);
            req_waits = '0;
            req_width = ECS_W32;
        end else if (i_req_sel == ECS_SEL_ROM) begin
            req_cfg   = ecs_cfg_s'(8'h00);
            req_waits = '0;
            req_width = ECS_W8;
        end else if (req_card) begin
            req_cfg   = ecs_cfg_s'(8'h00);                 // byte ignored
            req_waits = '{rnd_waits: CARD_W, seq_waits: CARD_W};
            req_width = ECS_W16;
            req_mux   = 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // access sequencer
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {ECS_ST_IDLE, ECS_ST_ACCESS, ECS_ST_LINGER} ecs_state_e;

    ecs_state_e state_r, state_nxt;
    logic [2:0] sel_r,    sel_nxt;     // select in use
    logic [3:0] wcnt_r,   wcnt_nxt;    // waits left
    logic       clken_r,  clken_nxt;   // clock gating of current select
    logic       seqen_r,  seqen_nxt;   // sequential enable of current select
    logic       page_r,   page_nxt;    // a page run is open
    logic [1:0] pcnt_r,   pcnt_nxt;    // sequential words issued in the run
    logic [1:0] act_r,    act_nxt;     // select-active cycles since an idle
    logic       busy_nxt;
    logic       done_r,   done_nxt;
    logic [SEL_COUNT-1:0] csn_r, csn_nxt;
    logic       eclk_r,   eclk_nxt;
    ecs_width_e width_r,  width_nxt;
    logic       mux_r,    mux_nxt;
    logic       take;                  // request accepted this cycle
    logic       gap;                   // forced idle cycle of the select
    logic       seq_hit;               // request gets page timing

    // a request is a one-cycle strobe while busy is low
    always_comb begin
        state_nxt = state_r;
        sel_nxt   = sel_r;
        wcnt_nxt  = wcnt_r;
        clken_nxt = clken_r;
        seqen_nxt = seqen_r;
        page_nxt  = page_r;
        pcnt_nxt  = pcnt_r;
        act_nxt   = act_r;
        busy_nxt  = busy_r;
        done_nxt  = 1'b0;
        width_nxt = width_r;
        mux_nxt   = mux_r;
        take      = i_req_valid && !busy_r;
        gap       = (state_r == ECS_ST_LINGER) && !seqen_r && (act_r == ECS_ACT_LIMIT);
        seq_hit   = req_cfg.seq_access_enable && i_req_seq && page_r
                 && (state_r == ECS_ST_LINGER) && (i_req_sel == sel_r);
        case (state_r)
            ECS_ST_IDLE, ECS_ST_LINGER: begin
                if (take) begin
                    state_nxt = ECS_ST_ACCESS;
                    sel_nxt   = i_req_sel;
                    clken_nxt = req_cfg.exp_clock_enable;
                    seqen_nxt = req_cfg.seq_access_enable;
                    width_nxt = req_width;
                    mux_nxt   = req_mux;
                    busy_nxt  = 1'b1;
                    if (seq_hit) begin
                        wcnt_nxt = req_waits.seq_waits;
                        pcnt_nxt = 2'(pcnt_r + 2'h1);
                        page_nxt = (pcnt_r != 2'(ECS_PAGE_LAST - 2'h1));
                    end else begin
                        wcnt_nxt = req_waits.rnd_waits;
                        pcnt_nxt = 2'h0;
                        page_nxt = req_cfg.seq_access_enable && (i_req_addr[3:2] == 2'h0);
                    end
                end else begin
                    state_nxt = ECS_ST_IDLE;                       // linger lasts one cycle
                end
            end
            ECS_ST_ACCESS: begin
                if (wcnt_r != 4'h0) begin
                    wcnt_nxt = 4'(wcnt_r - 4'h1);
                end else if (rdy_r || sel_r == ECS_SEL_SRAM || sel_r == ECS_SEL_ROM) begin
                    // on-chip selects never wait on the pin; ready low stretches
                    state_nxt = ECS_ST_LINGER;
                    busy_nxt  = 1'b0;
                    done_nxt  = 1'b1;
                end
            end
            default: begin
                state_nxt = ECS_ST_IDLE;
                busy_nxt  = 1'b0;
            end
        endcase
        // select line: low during an access and its linger, high on a gap
        csn_nxt = {SEL_COUNT{1'b1}};
        if (state_nxt == ECS_ST_ACCESS
            || (state_nxt == ECS_ST_LINGER && !(seqen_nxt == 1'b0 && act_r == ECS_ACT_LIMIT))) begin
            csn_nxt[sel_nxt] = 1'b0;
        end
        if (gap || state_nxt == ECS_ST_IDLE) begin
            act_nxt = 2'h0;
        end else if (act_r != ECS_ACT_LIMIT) begin
            act_nxt = 2'(act_r + 2'h1);
        end
        // gated clock runs across access and linger, so a following
        // access sees no stop
        if (state_nxt != ECS_ST_IDLE && clken_nxt) begin
            eclk_nxt = !eclk_r;
        end else begin
            eclk_nxt = 1'b0;
        end
    end

    // registers of the sequencer
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            state_r <= ECS_ST_IDLE;
            sel_r   <= 3'h0;
            wcnt_r  <= 4'h0;
            clken_r <= 1'b0;
            seqen_r <= 1'b0;
            page_r  <= 1'b0;
            pcnt_r  <= 2'h0;
            act_r   <= 2'h0;
            busy_r  <= 1'b0;
            done_r  <= 1'b0;
            csn_r   <= {SEL_COUNT{1'b1}};
            eclk_r  <= 1'b0;
            width_r <= ECS_W32;
            mux_r   <= 1'b0;
        end else begin
            state_r <= state_nxt;
            sel_r   <= sel_nxt;
            wcnt_r  <= wcnt_nxt;
            clken_r <= clken_nxt;
            seqen_r <= seqen_nxt;
            page_r  <= page_nxt;
            pcnt_r  <= pcnt_nxt;
            act_r   <= act_nxt;
            busy_r  <= busy_nxt;
            done_r  <= done_nxt;
            csn_r   <= csn_nxt;
            eclk_r  <= eclk_nxt;
            width_r <= width_nxt;
            mux_r   <= mux_nxt;
        end
    end

    // outputs straight from flops
    assign o_busy                = busy_r;
    assign o_done                = done_r;
    assign o_chip_select_n       = csn_r;
    assign o_expansion_clock_out = eclk_r;
    assign o_bus_width           = width_r;
    assign o_mux_mode            = mux_r;
    assign o_wait_count          = wcnt_r;

endmodule // ecs_top
`default_nettype wire

// >>> ecs_top_sva.sv
// checker: port-level timing properties of the expansion select block
`timescale 1ns/1ps
`default_nettype none
module ecs_top_sva
    import ecs_pkg::*;
#(
    parameter int SEL_COUNT = 8   // select lines watched
) (
    input wire logic                 i_clk,
    input wire logic                 i_rst_n,
    input wire logic                 i_rd,
    input wire logic                 i_req_valid,
    input wire logic [2:0]           i_req_sel,
    input wire logic                 i_expansion_ready_in,
    input wire logic [31:0]          o_rdata,
    input wire logic                 o_busy,
    input wire logic                 o_done,
    input wire logic [SEL_COUNT-1:0] o_chip_select_n,
    input wire logic                 o_expansion_clock_out,
    input wire logic                 o_mux_mode
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    // a request that the sequencer accepts
    sequence s_take;
        i_req_valid && !o_busy && i_expansion_ready_in;
    endsequence
    // zero-wait access: busy one cycle, then done
    sequence s_zero_wait;
        ##1 o_busy ##1 o_done;
    endsequence
    chk_sram_zero_wait: assert property (
        s_take ##0 (i_req_sel == ECS_SEL_SRAM) |-> s_zero_wait) else $error("sram waits");
    chk_rom_zero_wait: assert property (
        s_take ##0 (i_req_sel == ECS_SEL_ROM) |-> s_zero_wait) else $error("rom waits");
    chk_busy_on_take: assert property (
        i_req_valid && !o_busy |=> o_busy && !o_done) else $error("take lost");
    chk_busy_bounded: assert property (
        $rose(o_busy) |-> ##[1:40] o_done) else $error("access never ends");
    chk_cs_one_hot: assert property (
        o_busy |-> $onehot(~o_chip_select_n)) else $error("select not one-hot");
    chk_clock_gated: assert property (
        !o_busy [*4] |-> !o_expansion_clock_out) else $error("clock while idle");
    chk_mux_card: assert property (
        o_mux_mode && o_busy |-> !(o_chip_select_n[4] && o_chip_select_n[5]))
        else $error("mux without card");
    chk_rdata_idle: assert property (
        !$past(i_rd) |-> o_rdata == 32'h0) else $error("stray read data");
    chk_reset_idle: assert property (
        $rose(i_rst_n) |-> &o_chip_select_n && !o_busy) else $error("not idle");
endmodule // ecs_top_sva
bind ecs_top ecs_top_sva #(.SEL_COUNT(SEL_COUNT)) sva_u (.i_clk, .i_rst_n, .i_rd,
    .i_req_valid, .i_req_sel, .i_expansion_ready_in, .o_rdata, .o_busy, .o_done,
    .o_chip_select_n, .o_expansion_clock_out, .o_mux_mode);
`default_nettype wire

// >>> ecs_ready_model.sv
// partner: far-side device that stretches cycles by holding ready low
`timescale 1ns/1ps
`default_nettype none
module ecs_ready_model (
    // link side
    input  wire logic       i_lnk_clk,
    input  wire logic [7:0] i_chip_select_n,
    input  wire logic [4:0] i_stall,
    // ready back to the block
    output logic            o_ready
);
    logic [4:0] held_r = 5'h00;  // link cycles stalled in this access
    initial o_ready = 1'b1;
    // ready falls once selected, rises after the stall count
    always @(posedge i_lnk_clk) begin
        if (&i_chip_select_n) begin
            held_r  <= 5'h00;
            o_ready <= 1'b1;
        end else if (held_r < i_stall) begin
            held_r  <= held_r + 5'h01;
            o_ready <= 1'b0;
        end else begin
            o_ready <= 1'b1;
        end
    end
endmodule // ecs_ready_model
`default_nettype wire

// >>> ecs_top_test.sv
// testbench: register and access sequences for the expansion select block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin err_total++; \
    $display("CHECK FAILED %s exp %0h got %0h", nm, ex, got); end end
module ecs_top_test;
    import ecs_pkg::*;
    logic       i_clk, i_rst_n, i_lnk_clk, i_wr, i_rd, i_req_valid, i_req_seq;
    logic       ready, busy, done, eclk, mux, tog, mx, pend;
    logic [1:0] boot;
    logic [3:0] wcnt;
    logic [7:0] i_addr, cs_n;
    logic [2:0] i_req_sel;
    logic [4:0] stall;
    logic [27:0] i_req_addr;
    logic [31:0] i_wdata, rdata;
    ecs_width_e width;
    int         checks, err_total, cyc;
    ecs_top #(.SEL_COUNT(8), .CARD_WAITS(2)) dut_u (.i_clk, .i_rst_n, .i_lnk_clk,
        .i_lnk_rst_n(i_rst_n), .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata(rdata),
        .i_req_valid, .i_req_sel, .i_req_seq, .i_req_addr, .o_busy(busy), .o_done(done),
        .i_boot_width_strap(boot), .i_expansion_ready_in(ready), .o_chip_select_n(cs_n),
        .o_expansion_clock_out(eclk), .o_bus_width(width), .o_mux_mode(mux), .o_wait_count(wcnt));
    ecs_ready_model far_u (.i_lnk_clk, .i_chip_select_n(cs_n), .i_stall(stall), .o_ready(ready));
    initial begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end
    initial begin
        i_lnk_clk = 1'b0;
        #3.3;
        forever #7.5 i_lnk_clk = ~i_lnk_clk;
    end
    task automatic close_out;
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // hang guard: whole run needs well under this many cycles
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 5000) begin
            err_total++;
            close_out();
        end
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] ex);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1;
        `CHK("rdata", ex, rdata)
    endtask
    // one access; w waits expected, ge asks only for a longer cycle;
    // bb leaves a cycle early so the next request is taken in the linger cycle
    task automatic acc(input logic [2:0] s, input logic sq, input logic [1:0] q,
                       input int w, input ecs_width_e ew, input logic ge, input logic bb = 1'b0);
        int n;
        @(posedge i_clk);
        i_req_valid <= 1'b1;
        i_req_sel <= s;
        i_req_seq <= sq;
        i_req_addr <= {24'h0, q, 2'b00};
        #1;
        if (pend) `CHK("done", 1'b1, done)
        pend = bb;
        @(posedge i_clk);
        i_req_valid <= 1'b0;
        #1;
        `CHK("width", ew, width)
        mx = mux;
        tog = eclk;
        n = 0;
        while (done !== 1'b1 && !(bb && busy && wcnt == 4'h0) && n < 60) begin
            @(posedge i_clk);
            #1;
            n++;
            tog = tog | eclk;
        end
        `CHK("cycles", 1'b1, ge ? n > w + 1 : n + bb == w + 1)
    endtask
    initial begin
        {i_rst_n, i_wr, i_rd, i_req_valid, i_req_seq, i_addr, i_req_sel} = '0;
        {i_wdata, i_req_addr, stall, checks, err_total, cyc, boot, pend} = '0;
        repeat (5) @(posedge i_clk);
        i_rst_n <= 1'b1;
        repeat (4) @(posedge i_clk);
        rd(ECS_OFF_CFG_LO, 32'h0);
        rd(ECS_OFF_CTRL, 32'h0);
        wr(ECS_OFF_CFG_HI, 32'hFFFF_A5C3);
        rd(ECS_OFF_CFG_HI, 32'h0000_A5C3);
        wr(ECS_OFF_CTRL, 32'h4);
        for (int f = 0; f < 16; f++) begin
            wr(ECS_OFF_CFG_LO, 32'(f) << 2);
            acc(3'h0, 1'b0, 2'h0, 8 - 4 * f[2] - f[1:0], ECS_W32, 1'b0);
            `CHK("eclk", 1'b0, tog)
        end
        wr(8'hF0, 32'h1234_5678);
        rd(ECS_OFF_CFG_LO, 32'h0000_003C);
        for (int c = 0; c < 3; c++) begin
            wr(ECS_OFF_CFG_LO, 32'h0000_3C00 | (32'(c) << 8));
            acc(3'h1, 1'b0, 2'h0, 1, ecs_width_e'(c), 1'b0);
        end
        wr(ECS_OFF_CTRL, 32'h0);
        for (int f = 0; f < 4; f++) begin
            wr(ECS_OFF_CFG_LO, 32'(f) << 2);
            acc(3'h0, 1'b0, 2'h0, 4 - f, ECS_W32, 1'b0);
        end
        wr(ECS_OFF_CTRL, 32'h4);
        wr(ECS_OFF_CFG_LO, 32'h0050_0000);
        acc(3'h2, 1'b0, 2'h0, 4, ECS_W32, 1'b0, 1'b1);
        for (int q = 1; q < 4; q++) acc(3'h2, 1'b1, 2'(q), 2, ECS_W32, 1'b0, 1'b1);
        acc(3'h2, 1'b1, 2'h0, 4, ECS_W32, 1'b0);
        wr(ECS_OFF_CFG_LO, 32'h8000_0000);
        acc(3'h3, 1'b0, 2'h0, 8, ECS_W32, 1'b0, 1'b1);
        `CHK("eclk", 1'b1, tog)
        acc(3'h3, 1'b0, 2'h0, 8, ECS_W32, 1'b0);
        `CHK("eclk", 1'b1, tog)
        acc(3'h6, 1'b0, 2'h0, 0, ECS_W32, 1'b0);
        acc(3'h7, 1'b0, 2'h0, 0, ECS_W8, 1'b0);
        wr(ECS_OFF_CFG_HI, 32'h0000_00FF);
        wr(ECS_OFF_CTRL, 32'h5);
        acc(3'h4, 1'b0, 2'h0, 2, ECS_W16, 1'b0);
        `CHK("mux", 1'b1, mx)
        wr(ECS_OFF_CTRL, 32'h4);
        acc(3'h4, 1'b0, 2'h0, 1, ECS_WRES, 1'b0);
        `CHK("mux", 1'b0, mx)
        wr(ECS_OFF_CFG_LO, 32'h0);
        stall <= 5'h10;
        acc(3'h0, 1'b0, 2'h0, 8, ECS_W32, 1'b1);
        stall <= 5'h00;
        acc(3'h0, 1'b0, 2'h0, 8, ECS_W32, 1'b0);
        // second reset with the strap moved: width table follows it
        @(posedge i_clk);
        boot <= 2'h1;
        i_rst_n <= 1'b0;
        repeat (5) @(posedge i_clk);
        i_rst_n <= 1'b1;
        repeat (4) @(posedge i_clk);
        rd(ECS_OFF_STAT, 32'h0000_0009);
        wr(ECS_OFF_CTRL, 32'h4);
        wr(ECS_OFF_CFG_LO, 32'h0000_3C00);
        acc(3'h1, 1'b0, 2'h0, 1, ECS_W8, 1'b0);
        close_out();
    end
endmodule // ecs_top_test
`default_nettype wire
